// file: card_link_regs.svh
// timing counts and widths shared by both ends of the card link
// assumes a 25 MHz mclk on both ends
`ifndef CARD_LINK_REGS_SVH
`define CARD_LINK_REGS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define DATA_W 16
`define SYNC_DEV_W 22
`define SYNC_HOST_W 19

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 25
// host data strobe period in ns, a data half and an edge half per word edge
`define HSTB_PERIOD_NS 320
`define HSTB_HALF_CYC ((`HSTB_PERIOD_NS * `CLK_MHZ) / 2000)
// card data-in strobe half period in ns
`define DSTB_HALF_NS 320
`define DSTB_HALF_CYC ((`DSTB_HALF_NS * `CLK_MHZ) / 1000)
// read and write strobe width in ns, also used as hold and recovery
`define PIO_STROBE_NS 400
`define PIO_STROBE_CYC ((`PIO_STROBE_NS * `CLK_MHZ) / 1000)
// words the host moves per acknowledge
`define BURST_WORDS 8

`endif

// file: card_link_pkg.sv
// types shared by both ends of the card link
// assumes card_link_regs.svh for the widths
`include "card_link_regs.svh"

package card_link_pkg;

    // ----------------------------------------
    // phases
    // ----------------------------------------
    typedef enum logic [1:0] {DEV_IDLE, DEV_REQ, DEV_XFER} dev_phase_t;

    typedef enum logic [2:0] {
        H_IDLE, H_PIO_RD, H_PIO_WR, H_HOLD, H_WAIT_RQ, H_MW, H_UDMA, H_END
    } host_phase_t;

    typedef enum logic [1:0] {CMD_IO_RD, CMD_IO_WR, CMD_DMA} cmd_kind_t;

    // ----------------------------------------
    // state records
    // ----------------------------------------
    typedef struct packed {
        dev_phase_t phase;
        logic dmarq;
        logic dmarq_oe_n;
        logic inpack_n;
        logic [`DATA_W-1:0] dout;
        logic dout_oe_n;
        logic dstrobe;
        logic iord_q;
        logic iowr_q;
        logic started;
        logic halted;
        logic [7:0] pace;
        logic [`DATA_W-1:0] rx_word;
        logic rx_valid;
        logic word_taken;
        logic dma_active;
    } dev_state_t;

    typedef struct packed {
        host_phase_t phase;
        logic ata_sel_n;
        logic cs0_n;
        logic cs1_n;
        logic iord_n;
        logic iowr_n;
        logic dmack_n;
        logic [`DATA_W-1:0] dout;
        logic dout_oe_n;
        logic udma;
        logic rd_dir;
        logic tog;
        logic dstb_q;
        logic [7:0] cnt;
        logic [7:0] words;
        logic [`DATA_W-1:0] rx_word;
        logic rx_valid;
        logic word_taken;
        logic busy;
    } host_state_t;

endpackage

// file: card_link_if.sv
// pins between the card and its host controller
// assumes the bench drives no pin itself; shared lines resolve here
`timescale 1ns/100ps
`include "card_link_regs.svh"

interface card_link_if;
    logic ata_sel_n;
    logic cs0_n;
    logic cs1_n;
    logic iord_n;
    logic iowr_n;
    logic dmack_n;
    logic [`DATA_W-1:0] host_d;
    logic host_d_oe_n;
    logic [`DATA_W-1:0] card_d;
    logic card_d_oe_n;
    logic [`DATA_W-1:0] d;
    logic dmarq_o;
    logic dmarq_oe_n;
    logic dmarq;
    logic inpack_n;
    logic dstrobe;

    // ----------------------------------------
    // shared wires
    // ----------------------------------------
    // data lines float high, the request line is pulled low
    assign d = !card_d_oe_n ? card_d : (!host_d_oe_n ? host_d : 16'hffff);
    assign dmarq = !dmarq_oe_n ? dmarq_o : 1'b0;

    modport card (
        input ata_sel_n, cs0_n, cs1_n, iord_n, iowr_n, dmack_n, d,
        output card_d, card_d_oe_n, dmarq_o, dmarq_oe_n, inpack_n, dstrobe
    );

    modport host (
        output ata_sel_n, cs0_n, cs1_n, iord_n, iowr_n, dmack_n, host_d,
        output host_d_oe_n,
        input d, dmarq, inpack_n, dstrobe
    );
endinterface

// file: sync2.sv
// two-flop synchroniser for a bundle of pin inputs
// assumes each bit is a level held for several mclk cycles
`timescale 1ns/100ps

module sync2 #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk) begin
        if (srst) begin
            meta <= '1;
            dout <= '1;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// file: card_end.sv
// card end of the host port: input acknowledge, read strobe, dma request
// handshake, multiword and ultra dma transfers
// assumes one mclk, a host end on card_link_if, and user logic that
// supplies words on tx_word and takes them on rx_word
`timescale 1ns/100ps
`include "card_link_regs.svh"

module card_end (
    input wire logic mclk,
    input wire logic srst,
    card_link_if.card link,
    input wire logic io_mode,
    input wire logic dev_selected,
    input wire logic udma_en,
    input wire logic udma_read,
    input wire logic xfer_pending,
    input wire logic [`DATA_W-1:0] tx_word,
    output logic tx_taken,
    output logic [`DATA_W-1:0] rx_word,
    output logic rx_valid,
    output logic dma_active
);
    card_link_pkg::dev_state_t st;
    card_link_pkg::dev_state_t next_st;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [`SYNC_DEV_W-1:0] pins_raw;
    logic [`SYNC_DEV_W-1:0] pins_s;
    logic ata_sel_s;
    logic cs0_s;
    logic cs1_s;
    logic iord_s;
    logic iowr_s;
    logic dmack_s;
    logic [`DATA_W-1:0] d_s;

    // the data strobe travels with its data so both see the same delay
    assign pins_raw = {link.ata_sel_n, link.cs0_n, link.cs1_n, link.iord_n,
                       link.iowr_n, link.dmack_n, link.d};

    sync2 #(.W(`SYNC_DEV_W)) u_sync (
        .mclk(mclk),
        .srst(srst),
        .din(pins_raw),
        .dout(pins_s)
    );

    assign {ata_sel_s, cs0_s, cs1_s, iord_s, iowr_s, dmack_s, d_s} = pins_s;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic ide;
    logic dma_on;
    logic udma_on;
    logic rd_act;
    logic pio_sel;
    logic iord_rise;
    logic iowr_rise;
    logic hstb_edge;
    logic stop;

    always_comb begin
        ide = ~ata_sel_s;
        // acknowledge counts only while a transfer was requested
        dma_on = ide && !dmack_s && st.phase == card_link_pkg::DEV_XFER;
        udma_on = dma_on && udma_en;
        // with ultra dma active the read pin is a pacing or strobe line
        rd_act = !iord_s && !udma_on;
        // in ide mode, selects are ignored while an acknowledge is held
        if (ide) begin
            pio_sel = dev_selected && dmack_s && (!cs0_s || !cs1_s);
        end else begin
            pio_sel = io_mode && !cs0_s;
        end
        iord_rise = iord_s && !st.iord_q;
        iowr_rise = iowr_s && !st.iowr_q;
        hstb_edge = iord_s != st.iord_q;
        stop = iowr_s;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.rx_valid = 1'b0;
        next_st.word_taken = 1'b0;
        next_st.iord_q = iord_s;
        next_st.iowr_q = iowr_s;
        next_st.dout_oe_n = 1'b1;
        next_st.inpack_n = 1'b1;
        next_st.dmarq_oe_n = !(ide && dev_selected);

        // acknowledge only for a selected io-mode read
        if (!ide && io_mode && pio_sel && rd_act) begin
            next_st.inpack_n = 1'b0;
        end

        // register and multiword reads put the user word on the bus
        if ((ide || io_mode) && rd_act && (pio_sel || (dma_on && !udma_en))) begin
            next_st.dout = tx_word;
            next_st.dout_oe_n = 1'b0;
        end
        if (iord_rise && !st.dout_oe_n && !udma_on) begin
            next_st.word_taken = 1'b1;
        end

        // register and multiword writes
        if (iowr_rise && (ide || io_mode) && (pio_sel || (dma_on && !udma_en))) begin
            next_st.rx_word = d_s;
            next_st.rx_valid = 1'b1;
        end

        unique case (st.phase)
            card_link_pkg::DEV_IDLE: begin
                next_st.started = 1'b0;
                next_st.halted = 1'b0;
                if (ide && dev_selected && xfer_pending) begin
                    next_st.dmarq = 1'b1;
                    next_st.phase = card_link_pkg::DEV_REQ;
                end
            end
            card_link_pkg::DEV_REQ: begin
                if (!dmack_s) begin
                    next_st.dmarq = 1'b0;
                    next_st.dma_active = 1'b1;
                    next_st.phase = card_link_pkg::DEV_XFER;
                end else if (!ide || !dev_selected) begin
                    next_st.dmarq = 1'b0;
                    next_st.phase = card_link_pkg::DEV_IDLE;
                end
            end
            card_link_pkg::DEV_XFER: begin
                if (dmack_s || !ide) begin
                    // back to idle, which asks again if words remain
                    next_st.dma_active = 1'b0;
                    next_st.phase = card_link_pkg::DEV_IDLE;
                end else if (udma_on) begin
                    if (!st.started && !stop) begin
                        next_st.started = 1'b1;
                        next_st.pace = 8'(`DSTB_HALF_CYC);
                    end
                    if (st.started && stop) begin
                        next_st.halted = 1'b1;
                    end
                    if (st.started && !st.halted && !stop) begin
                        if (!udma_read) begin
                            // every host strobe edge carries one word
                            if (hstb_edge) begin
                                next_st.rx_word = d_s;
                                next_st.rx_valid = 1'b1;
                            end
                        end else begin
                            next_st.dout = tx_word;
                            next_st.dout_oe_n = 1'b0;
                            // ready negated freezes the pace counter
                            if (!iord_s) begin
                                if (st.pace == 8'h00) begin
                                    next_st.pace = 8'(`DSTB_HALF_CYC);
                                    next_st.dstrobe = !st.dstrobe;
                                    next_st.word_taken = 1'b1;
                                end else begin
                                    next_st.pace = st.pace - 8'h01;
                                end
                            end
                        end
                    end
                end
            end
        endcase

        if (srst) begin
            next_st = '0;
            next_st.phase = card_link_pkg::DEV_IDLE;
            next_st.dmarq_oe_n = 1'b1;
            next_st.inpack_n = 1'b1;
            next_st.dout_oe_n = 1'b1;
            next_st.iord_q = 1'b1;
            next_st.iowr_q = 1'b1;
        end
    end

    // ----------------------------------------
    // state register and outputs
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign link.card_d = st.dout;
    assign link.card_d_oe_n = st.dout_oe_n;
    assign link.dmarq_o = st.dmarq;
    assign link.dmarq_oe_n = st.dmarq_oe_n;
    assign link.inpack_n = st.inpack_n;
    assign link.dstrobe = st.dstrobe;
    assign tx_taken = st.word_taken;
    assign rx_word = st.rx_word;
    assign rx_valid = st.rx_valid;
    assign dma_active = st.dma_active;
endmodule

// file: host_end.sv
// host controller end of the card link: register reads and writes,
// multiword and ultra dma bursts of a fixed word count
// assumes one mclk and a card end on card_link_if
`timescale 1ns/100ps
`include "card_link_regs.svh"

module host_end (
    input wire logic mclk,
    input wire logic srst,
    card_link_if.host link,
    input wire logic ide_mode,
    input wire logic cmd_valid,
    input wire card_link_pkg::cmd_kind_t cmd_kind,
    input wire logic cmd_udma,
    input wire logic cmd_read,
    input wire logic [`DATA_W-1:0] cmd_word,
    input wire logic host_ready,
    output logic word_taken,
    output logic [`DATA_W-1:0] rx_word,
    output logic rx_valid,
    output logic busy
);
    card_link_pkg::host_state_t st;
    card_link_pkg::host_state_t next_st;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [`SYNC_HOST_W-1:0] pins_s;
    logic dmarq_sn;
    logic dstb_sn;
    logic dmarq_s;
    logic dstb_s;
    logic inpack_s;
    logic [`DATA_W-1:0] d_s;

    sync2 #(.W(`SYNC_HOST_W)) u_sync (
        .mclk(mclk),
        .srst(srst),
        // request and data-in strobe go in inverted so the flushed ones match their idle lows
        .din({!link.dmarq, !link.dstrobe, link.inpack_n, link.d}),
        .dout(pins_s)
    );

    assign {dmarq_sn, dstb_sn, inpack_s, d_s} = pins_s;
    assign dmarq_s = !dmarq_sn;
    assign dstb_s = !dstb_sn;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.rx_valid = 1'b0;
        next_st.word_taken = 1'b0;
        next_st.dstb_q = dstb_s;
        next_st.ata_sel_n = !ide_mode;
        next_st.cnt = (st.cnt == 8'h00) ? 8'h00 : st.cnt - 8'h01;

        unique case (st.phase)
            card_link_pkg::H_IDLE: begin
                next_st.busy = cmd_valid;
                next_st.udma = cmd_udma;
                next_st.rd_dir = cmd_read;
                next_st.cnt = 8'(`PIO_STROBE_CYC);
                if (cmd_valid && cmd_kind == card_link_pkg::CMD_IO_RD) begin
                    next_st.cs0_n = 1'b0;
                    next_st.iord_n = 1'b0;
                    next_st.phase = card_link_pkg::H_PIO_RD;
                end else if (cmd_valid && cmd_kind == card_link_pkg::CMD_IO_WR) begin
                    next_st.cs0_n = 1'b0;
                    next_st.dout = cmd_word;
                    next_st.dout_oe_n = 1'b0;
                    next_st.iowr_n = 1'b0;
                    next_st.phase = card_link_pkg::H_PIO_WR;
                end else if (cmd_valid && cmd_kind == card_link_pkg::CMD_DMA) begin
                    next_st.phase = card_link_pkg::H_WAIT_RQ;
                end
            end
            card_link_pkg::H_PIO_RD: begin
                if (st.cnt == 8'h00) begin
                    // in io mode the acknowledge gates the input buffer
                    next_st.rx_valid = ide_mode || !inpack_s;
                    next_st.rx_word = d_s;
                    next_st.iord_n = 1'b1;
                    next_st.cs0_n = 1'b1;
                    next_st.busy = 1'b0;
                    next_st.phase = card_link_pkg::H_IDLE;
                end
            end
            card_link_pkg::H_PIO_WR: begin
                if (st.cnt == 8'h00) begin
                    next_st.iowr_n = 1'b1;
                    next_st.word_taken = 1'b1;
                    next_st.cnt = 8'(`PIO_STROBE_CYC);
                    next_st.phase = card_link_pkg::H_HOLD;
                end
            end
            card_link_pkg::H_HOLD: begin
                // data and select stay put until the card has sampled
                if (st.cnt == 8'h00) begin
                    next_st.cs0_n = 1'b1;
                    next_st.dout_oe_n = 1'b1;
                    next_st.busy = 1'b0;
                    next_st.phase = card_link_pkg::H_IDLE;
                end
            end
            card_link_pkg::H_WAIT_RQ: begin
                next_st.words = 8'h00;
                next_st.tog = 1'b0;
                if (dmarq_s) begin
                    next_st.dmack_n = 1'b0;
                    next_st.cs0_n = 1'b1;
                    next_st.cs1_n = 1'b1;
                    if (st.udma) begin
                        next_st.iowr_n = 1'b0;
                        next_st.iord_n = st.rd_dir ? !host_ready : 1'b1;
                        next_st.dout_oe_n = st.rd_dir;
                        next_st.dout = cmd_word;
                        next_st.cnt = 8'(`HSTB_HALF_CYC);
                        next_st.phase = card_link_pkg::H_UDMA;
                    end else begin
                        next_st.dout = cmd_word;
                        next_st.dout_oe_n = st.rd_dir;
                        next_st.iord_n = !st.rd_dir;
                        next_st.iowr_n = st.rd_dir;
                        next_st.cnt = 8'(`PIO_STROBE_CYC);
                        next_st.phase = card_link_pkg::H_MW;
                    end
                end
            end
            card_link_pkg::H_MW: begin
                if (st.cnt == 8'h00) begin
                    next_st.cnt = 8'(`PIO_STROBE_CYC);
                    if (!st.iord_n || !st.iowr_n) begin
                        next_st.iord_n = 1'b1;
                        next_st.iowr_n = 1'b1;
                        next_st.rx_word = d_s;
                        next_st.rx_valid = st.rd_dir;
                        next_st.word_taken = !st.rd_dir;
                        next_st.words = st.words + 8'h01;
                    end else if (st.words == 8'(`BURST_WORDS)) begin
                        next_st.phase = card_link_pkg::H_END;
                    end else begin
                        next_st.dout = cmd_word;
                        next_st.iord_n = !st.rd_dir;
                        next_st.iowr_n = st.rd_dir;
                    end
                end
            end
            card_link_pkg::H_UDMA: begin
                if (st.rd_dir) begin
                    next_st.iord_n = !host_ready;
                    if (dstb_s != st.dstb_q) begin
                        next_st.rx_word = d_s;
                        next_st.rx_valid = 1'b1;
                        next_st.words = st.words + 8'h01;
                    end
                    if (st.words == 8'(`BURST_WORDS)) begin
                        next_st.phase = card_link_pkg::H_END;
                    end
                end else if (st.cnt == 8'h00 && host_ready) begin
                    // data changes half a period before its edge
                    next_st.cnt = 8'(`HSTB_HALF_CYC);
                    next_st.tog = !st.tog;
                    if (!st.tog) begin
                        next_st.dout = cmd_word;
                    end else begin
                        next_st.iord_n = !st.iord_n;
                        next_st.word_taken = 1'b1;
                        next_st.words = st.words + 8'h01;
                        if (st.words == 8'(`BURST_WORDS - 1)) begin
                            next_st.phase = card_link_pkg::H_END;
                        end
                    end
                end
            end
            card_link_pkg::H_END: begin
                // stop first, acknowledge released once the card has seen it
                next_st.iowr_n = 1'b1;
                next_st.iord_n = 1'b1;
                if (st.iowr_n && st.cnt == 8'h00) begin
                    next_st.dmack_n = 1'b1;
                    next_st.dout_oe_n = 1'b1;
                    next_st.busy = 1'b0;
                    next_st.phase = card_link_pkg::H_IDLE;
                end else if (!st.iowr_n) begin
                    next_st.cnt = 8'(`PIO_STROBE_CYC);
                end
            end
            default: begin
                next_st.phase = card_link_pkg::H_IDLE;
            end
        endcase

        if (srst) begin
            next_st = '0;
            next_st.phase = card_link_pkg::H_IDLE;
            next_st.ata_sel_n = 1'b1;
            next_st.cs0_n = 1'b1;
            next_st.cs1_n = 1'b1;
            next_st.iord_n = 1'b1;
            next_st.iowr_n = 1'b1;
            next_st.dmack_n = 1'b1;
            next_st.dout_oe_n = 1'b1;
        end
    end

    // ----------------------------------------
    // state register and outputs
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign link.ata_sel_n = st.ata_sel_n;
    assign link.cs0_n = st.cs0_n;
    assign link.cs1_n = st.cs1_n;
    assign link.iord_n = st.iord_n;
    assign link.iowr_n = st.iowr_n;
    assign link.dmack_n = st.dmack_n;
    assign link.host_d = st.dout;
    assign link.host_d_oe_n = st.dout_oe_n;
    assign word_taken = st.word_taken;
    assign rx_word = st.rx_word;
    assign rx_valid = st.rx_valid;
    assign busy = st.busy;
endmodule

// file: card_link_props.sv
// concurrent checks on the card link pins
// assumes the bench instantiates it beside the interface joining both ends
`timescale 1ns/100ps

module card_link_props (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ata_sel_n,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic iord_n,
    input wire logic dmack_n,
    input wire logic card_d_oe_n,
    input wire logic dmarq_o,
    input wire logic dmarq_oe_n,
    input wire logic inpack_n,
    input wire logic dstrobe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_ack_cause;
        $fell(inpack_n) |-> !$past(iord_n, 3) && !$past(cs0_n, 3);
    endproperty
    property p_ack_sync;
        $fell(iord_n) |-> inpack_n ##1 inpack_n;
    endproperty
    property p_bus_release;
        !card_d_oe_n |-> !$past(iord_n, 3) || !$past(dmack_n, 3);
    endproperty
    property p_rq_sel;
        !dmarq_oe_n |-> !$past(ata_sel_n, 3);
    endproperty
    property p_rq_hold;
        dmarq_o && dmack_n && $past(dmack_n, 2) |=> dmarq_o;
    endproperty
    property p_rq_reraise;
        $rose(dmarq_o) |-> $past(dmack_n, 2) && $past(dmack_n, 3);
    endproperty
    property p_dma_cs;
        !dmack_n |-> cs0_n && cs1_n;
    endproperty
    property p_strobe_pace;
        $changed(dstrobe) |=> $stable(dstrobe) [*8];
    endproperty

    a_ack_cause: assert property (p_ack_cause) else $error("ack without read");
    a_ack_sync: assert property (p_ack_sync) else $error("ack too early");
    a_bus_release: assert property (p_bus_release) else $error("bus driven");
    a_rq_sel: assert property (p_rq_sel) else $error("request driven");
    a_rq_hold: assert property (p_rq_hold) else $error("request dropped");
    a_rq_reraise: assert property (p_rq_reraise) else $error("request in ack");
    a_dma_cs: assert property (p_dma_cs) else $error("select during dma");
    a_strobe_pace: assert property (p_strobe_pace) else $error("strobe pace");

    c_ack: cover property ($fell(inpack_n));
    c_rq: cover property ($fell(dmarq_o));
    c_strobe: cover property ($changed(dstrobe));
endmodule

// file: card_io_dma_strobe_handshake_tb.sv
// bench joining card and host ends, driving commands on the host side
// assumes the two ends, the interface and the checker are compiled first
`timescale 1ns/100ps

module card_io_dma_strobe_handshake_tb;
    logic mclk = 0, srst = 1, io_mode = 0, dev_selected = 1, udma_en = 0;
    logic udma_read = 0, xfer_pending = 0, tx_taken, c_rxv, dma_active, ide_mode = 0;
    logic cmd_valid = 0, cmd_udma = 0, cmd_read = 0, host_ready = 1, word_taken;
    logic h_rxv, busy, pause = 0;
    logic [15:0] tx_word = 16'h0000, c_rx, cmd_word = 16'h0000, h_rx;
    card_link_pkg::cmd_kind_t cmd_kind = card_link_pkg::CMD_IO_RD;
    int c_n = 0, h_n = 0, ack_n = 0, cb, hb, ab, cyc = 0, miscompares = 0, compares = 0;
    int w_n = 0, t_n = 0, wb, tb;

    card_link_if lk();
    card_end i_card_end (.mclk(mclk), .srst(srst), .link(lk.card), .io_mode(io_mode),
        .dev_selected(dev_selected), .udma_en(udma_en), .udma_read(udma_read),
        .xfer_pending(xfer_pending), .tx_word(tx_word), .tx_taken(tx_taken),
        .rx_word(c_rx), .rx_valid(c_rxv), .dma_active(dma_active));
    host_end i_host_end (.mclk(mclk), .srst(srst), .link(lk.host), .ide_mode(ide_mode),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_udma(cmd_udma),
        .cmd_read(cmd_read), .cmd_word(cmd_word), .host_ready(host_ready),
        .word_taken(word_taken), .rx_word(h_rx), .rx_valid(h_rxv), .busy(busy));
    card_link_props u_props (.mclk(mclk), .srst(srst), .ata_sel_n(lk.ata_sel_n),
        .cs0_n(lk.cs0_n), .cs1_n(lk.cs1_n), .iord_n(lk.iord_n), .dmack_n(lk.dmack_n),
        .card_d_oe_n(lk.card_d_oe_n), .dmarq_o(lk.dmarq_o), .dmarq_oe_n(lk.dmarq_oe_n),
        .inpack_n(lk.inpack_n), .dstrobe(lk.dstrobe));

    always #20 mclk = ~mclk;

    // ----------------------------------------
    // event counters and host pause pattern
    // ----------------------------------------
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        c_n <= c_n + int'(c_rxv === 1'b1);
        h_n <= h_n + int'(h_rxv === 1'b1);
        ack_n <= ack_n + int'(lk.inpack_n === 1'b0);
        w_n <= w_n + int'(word_taken === 1'b1);
        t_n <= t_n + int'(tx_taken === 1'b1);
        host_ready <= !(pause && cyc[5]);
        if (dma_active === 1'b1) xfer_pending <= 1'b0;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic run(input card_link_pkg::cmd_kind_t k, input logic u, input logic r);
        cb = c_n;
        hb = h_n;
        ab = ack_n;
        wb = w_n;
        tb = t_n;
        @(posedge mclk);
        cmd_kind <= k;
        cmd_udma <= u;
        cmd_read <= r;
        cmd_valid <= 1'b1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        repeat (3000) begin
            @(posedge mclk);
            #1;
            if (busy === 1'b0) break;
        end
        repeat (8) @(posedge mclk);
    endtask

    task automatic wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        run(card_link_pkg::CMD_IO_RD, 1'b0, 1'b1);
        check("mem read words", h_n - hb, 0);
        check("mem ack", ack_n - ab, 0);
        $display("memory mode done");
        io_mode <= 1'b1;
        tx_word <= 16'h5aa5;
        run(card_link_pkg::CMD_IO_RD, 1'b0, 1'b1);
        check("io read word", h_rx, 16'h5aa5);
        check("io ack seen", ack_n != ab, 1);
        check("io read taken", t_n - tb, 1);
        cmd_word <= 16'hc33c;
        run(card_link_pkg::CMD_IO_WR, 1'b0, 1'b0);
        check("io write word", c_rx, 16'hc33c);
        check("io write count", c_n - cb, 1);
        check("io write taken", w_n - wb, 1);
        $display("io mode done");
        ide_mode <= 1'b1;
        tx_word <= 16'h1234;
        run(card_link_pkg::CMD_IO_RD, 1'b0, 1'b1);
        check("ide read word", h_rx, 16'h1234);
        xfer_pending <= 1'b1;
        run(card_link_pkg::CMD_DMA, 1'b0, 1'b0);
        check("mw dma words", c_n - cb, 8);
        check("mw dma word", c_rx, 16'hc33c);
        check("mw dma taken", w_n - wb, 8);
        tx_word <= 16'h9669;
        xfer_pending <= 1'b1;
        run(card_link_pkg::CMD_DMA, 1'b0, 1'b1);
        check("mw read words", h_n - hb, 8);
        check("mw read word", h_rx, 16'h9669);
        check("mw read taken", t_n - tb, 8);
        $display("multiword dma done");
        udma_en <= 1'b1;
        pause <= 1'b1;
        cmd_word <= 16'h0ff0;
        xfer_pending <= 1'b1;
        run(card_link_pkg::CMD_DMA, 1'b1, 1'b0);
        check("udma out words", c_n - cb, 8);
        check("udma out word", c_rx, 16'h0ff0);
        check("udma out taken", w_n - wb, 8);
        udma_read <= 1'b1;
        tx_word <= 16'h8421;
        xfer_pending <= 1'b1;
        run(card_link_pkg::CMD_DMA, 1'b1, 1'b1);
        check("udma in words", h_n - hb, 8);
        check("udma in word", h_rx, 16'h8421);
        $display("ultra dma done");
        dev_selected <= 1'b0;
        repeat (3) @(posedge mclk);
        check("rq undriven", lk.dmarq_oe_n, 1);
        $display("deselect done");
        wrap_up;
    end

    initial begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        wrap_up;
    end
endmodule
